// file: msc_change.sv
module msc_change
   import msc_pkg::*;
#(
   parameter int W = MSC_NUM_STS
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] level_i,
   output logic [W-1:0] change_o
);
   typedef struct packed {
      logic primed;
      logic [W-1:0] prev;
   } msc_change_state_t;

   msc_change_state_t s_q;
   msc_change_state_t s_d;

   if (W < 1) begin : g_chk
      $error("msc_change needs W of at least 1");
   end

   always_comb begin
      s_d = s_q;
      s_d.prev = level_i;
      s_d.primed = 1'b1;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // No false change from the reset value of the first sample
   assign change_o = s_q.primed ? (level_i ^ s_q.prev) : '0;
endmodule : msc_change

// file: msc_dce.sv
module msc_dce (
   input wire logic ref_clk_i,
   input wire logic slow_i,
   input wire logic [5:0] req_i,
   output logic [5:0] pin_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0][5:0] dly_q = '0;
   initial pin_b_o = 6'h3F;
   // Active low lines; slow mode lags four more cycles
   always @(posedge ref_clk_i) begin
      dly_q <= {dly_q[2:0], req_i};
      pin_b_o <= ~(slow_i ? dly_q[3] : req_i);
   end
endmodule : msc_dce

// file: msc_modem_ext.sv
// Local design decisions: the AHB-Lite slave port and the register addresses.
module msc_modem_ext
   import msc_pkg::*;
#(
   parameter int ADDR_W = MSC_ADDR_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [ADDR_W-1:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [MSC_DATA_W-1:0] hwdata_i,
   output logic [MSC_DATA_W-1:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic irq_o,
   input wire logic incoming_call_in_b_i,
   input wire logic test_mode_in_b_i,
   input wire logic signal_quality_in_b_i,
   input wire logic standby_indicator_in_b_i,
   input wire logic rate_indication_in_b_i,
   input wire logic receiver_ready_in_b_i,
   input wire logic tx_empty_i,
   output logic terminal_in_service_out_b_o,
   output logic frequency_select_out_b_o,
   output logic select_standby_out_b_o,
   output logic remote_loopback_out_b_o,
   output logic local_loopback_out_b_o,
   output logic new_signal_out_b_o,
   output logic change_or_tx_empty_pin_b_o
);
   typedef struct packed {
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [MSC_NUM_IEN-1:0] ien;
      logic [MSC_NUM_OUT-1:0] outreg;
      logic newsig_low;
      logic chg_flag;
      logic [1:0] ctl;
      logic [MSC_NUM_IRQ-1:0] irq_sts;
      logic [MSC_NUM_IRQ-1:0] irq_msk;
      logic [MSC_DATA_W-1:0] hrdata;
      logic hready;
      logic hresp;
      logic irq;
      logic [MSC_NUM_OUT-1:0] pin_b;
      logic chg_pin_b;
   } msc_top_state_t;

   msc_top_state_t s_q;
   msc_top_state_t s_d;

   logic [MSC_NUM_SYNC-1:0] raw_lvl;
   logic [MSC_NUM_SYNC-1:0] sync_lvl;
   logic [MSC_NUM_STS-1:0] sts_lvl;
   logic [MSC_NUM_STS-1:0] sts_chg;
   logic [MSC_NUM_STS-1:0] mirror;
   logic rdy_high;
   logic accept;
   logic det_en;
   logic chg_event;
   logic [7:0] wr_addr;
   logic [7:0] wdat;

   if (ADDR_W < 8) begin : g_chk
      $error("msc_modem_ext needs ADDR_W of at least 8");
   end

   // Word-aligned register select
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction : hit

   function automatic logic [MSC_DATA_W-1:0] widen8(input logic [7:0] v);
      widen8 = {24'h00_0000, v};
   endfunction : widen8

   assign raw_lvl = {receiver_ready_in_b_i,
                     rate_indication_in_b_i,
                     standby_indicator_in_b_i,
                     signal_quality_in_b_i,
                     test_mode_in_b_i,
                     incoming_call_in_b_i};

   msc_sync #(
      .W(MSC_NUM_SYNC)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .async_i(raw_lvl),
      .sync_o(sync_lvl)
   );

   assign sts_lvl = sync_lvl[MSC_NUM_STS-1:0];
   assign rdy_high = sync_lvl[MSC_SYNC_RDY];

   msc_change #(
      .W(MSC_NUM_STS)
   ) u_change (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .level_i(sts_lvl),
      .change_o(sts_chg)
   );

   // Low input reads as 1, bit order follows the input order
   assign mirror = ~sts_lvl;

   assign accept = hsel_i & hready_i & (htrans_i == MSC_HTRANS_NONSEQ);
   assign det_en = s_q.ctl[0] | s_q.ctl[1];
   assign chg_event = det_en &
      ((sts_chg[MSC_S2_CALL] & s_q.ien[MSC_IEN_CALL]) |
       (sts_chg[MSC_S2_TEST] & s_q.ien[MSC_IEN_TEST]) |
       ((sts_chg[MSC_S2_QUAL] | sts_chg[MSC_S2_STBY] |
         sts_chg[MSC_S2_RATE]) & s_q.ien[MSC_IEN_GRP]));
   assign wr_addr = s_q.addr;
   assign wdat = hwdata_i[7:0];

   always_comb begin
      s_d = s_q;
      s_d.hresp = 1'b0;

      // Read data phase: one wait state, then data and side effects
      if (s_q.rd_pend) begin
         s_d.rd_pend = 1'b0;
         s_d.hready = 1'b1;
         s_d.hrdata = MSC_RST_RDATA;
         if (hit(s_q.addr, MSC_OFF_STATUS_TWO)) begin
            s_d.hrdata = widen8({s_q.ien, mirror});
         end
         if (hit(s_q.addr, MSC_OFF_OUTPUT)) begin
            s_d.hrdata = widen8({2'h0, s_q.outreg});
         end
         if (hit(s_q.addr, MSC_OFF_STATUS_ONE)) begin
            s_d.hrdata = MSC_RST_RDATA;
            s_d.hrdata[MSC_S1_CHG] = s_q.chg_flag;
            s_d.chg_flag = 1'b0;
         end
         if (hit(s_q.addr, MSC_OFF_CONTROL)) begin
            s_d.hrdata = MSC_RST_RDATA;
            s_d.hrdata[MSC_CTL_TX_ON] = s_q.ctl[0];
            s_d.hrdata[MSC_CTL_RX_ON] = s_q.ctl[1];
         end
         if (hit(s_q.addr, MSC_OFF_IRQ_STS)) begin
            s_d.hrdata = widen8({6'h00, s_q.irq_sts});
         end
         if (hit(s_q.addr, MSC_OFF_IRQ_MSK)) begin
            s_d.hrdata = widen8({6'h00, s_q.irq_msk});
         end
      end

      // Write data phase: zero wait states
      if (s_q.wr_pend) begin
         s_d.wr_pend = 1'b0;
         if (hit(wr_addr, MSC_OFF_STATUS_TWO)) begin
            // Mirrored bits stay driven by the inputs
            s_d.ien = wdat[7:MSC_S2_IEN];
         end
         if (hit(wr_addr, MSC_OFF_OUTPUT)) begin
            s_d.outreg = wdat[MSC_NUM_OUT-1:0];
            if (wdat[MSC_OUT_NEWSIG]) begin
               s_d.newsig_low = 1'b1;
            end
         end
         if (hit(wr_addr, MSC_OFF_CONTROL)) begin
            s_d.ctl = {wdat[MSC_CTL_RX_ON], wdat[MSC_CTL_TX_ON]};
         end
         if (hit(wr_addr, MSC_OFF_IRQ_STS)) begin
            s_d.irq_sts = s_q.irq_sts & ~wdat[MSC_NUM_IRQ-1:0];
         end
         if (hit(wr_addr, MSC_OFF_IRQ_MSK)) begin
            s_d.irq_msk = wdat[MSC_NUM_IRQ-1:0];
         end
      end

      // Address phase
      if (accept) begin
         s_d.addr = haddr_i[7:0];
         if (hwrite_i) begin
            s_d.wr_pend = 1'b1;
         end else begin
            s_d.rd_pend = 1'b1;
            s_d.hready = 1'b0;
         end
      end

      // New-signal release once receiver ready is high
      if (!s_d.outreg[MSC_OUT_NEWSIG] && s_q.newsig_low && rdy_high) begin
         s_d.newsig_low = 1'b0;
         s_d.irq_sts[MSC_IRQ_NSREL] = 1'b1;
      end

      // Set wins over read clear and over write-one clear
      if (chg_event) begin
         s_d.chg_flag = 1'b1;
         s_d.irq_sts[MSC_IRQ_CHG] = 1'b1;
      end

      // Pin levels registered from next state
      s_d.pin_b = ~s_d.outreg;
      s_d.pin_b[MSC_OUT_NEWSIG] = ~s_d.newsig_low;
      s_d.chg_pin_b = ~(s_d.chg_flag | tx_empty_i);
      s_d.irq = |(s_d.irq_sts & s_d.irq_msk);
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q.wr_pend <= 1'b0;
         s_q.rd_pend <= 1'b0;
         s_q.addr <= 8'h00;
         s_q.ien <= MSC_RST_IEN;
         s_q.outreg <= MSC_RST_OUT;
         s_q.newsig_low <= 1'b0;
         s_q.chg_flag <= 1'b0;
         s_q.ctl <= MSC_RST_CTL;
         s_q.irq_sts <= MSC_RST_IRQ;
         s_q.irq_msk <= MSC_RST_IRQ;
         s_q.hrdata <= MSC_RST_RDATA;
         s_q.hready <= 1'b1;
         s_q.hresp <= 1'b0;
         s_q.irq <= 1'b0;
         s_q.pin_b <= {MSC_NUM_OUT{MSC_RST_PIN}};
         s_q.chg_pin_b <= MSC_RST_PIN;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata_o = s_q.hrdata;
   assign hreadyout_o = s_q.hready;
   assign hresp_o = s_q.hresp;
   assign irq_o = s_q.irq;
   assign terminal_in_service_out_b_o = s_q.pin_b[MSC_OUT_INSVC];
   assign frequency_select_out_b_o = s_q.pin_b[MSC_OUT_FREQ];
   assign select_standby_out_b_o = s_q.pin_b[MSC_OUT_STBY];
   assign remote_loopback_out_b_o = s_q.pin_b[MSC_OUT_REMOTE];
   assign local_loopback_out_b_o = s_q.pin_b[MSC_OUT_LOCAL];
   assign new_signal_out_b_o = s_q.pin_b[MSC_OUT_NEWSIG];
   assign change_or_tx_empty_pin_b_o = s_q.chg_pin_b;
endmodule : msc_modem_ext

// file: msc_modem_ext_tb.sv
module msc_modem_ext_tb
   import msc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = '0, rst_b_i = '0, hsel_i = '0, hwrite_i = '0;
   logic tx_empty_i = '0, slow = '0, dph_rd = '0, hreadyout_o, hresp_o, irq_o;
   logic [7:0] haddr_i = '0;
   logic [1:0] htrans_i = '0;
   logic [31:0] hwdata_i = '0, hrdata_o, seed = 32'h76F4;
   logic [5:0] req = '0;
   logic [31:0] expq [$];
   int n_errors = 0, tests_run = 0;
   wire incoming_call_in_b_i, test_mode_in_b_i, signal_quality_in_b_i;
   wire standby_indicator_in_b_i, rate_indication_in_b_i;
   wire receiver_ready_in_b_i;
   logic terminal_in_service_out_b_o, frequency_select_out_b_o;
   logic select_standby_out_b_o, remote_loopback_out_b_o;
   logic local_loopback_out_b_o, new_signal_out_b_o;
   logic change_or_tx_empty_pin_b_o;
   wire [4:0] opins = {terminal_in_service_out_b_o, frequency_select_out_b_o,
      select_standby_out_b_o, remote_loopback_out_b_o, local_loopback_out_b_o};
   msc_dce dce (.ref_clk_i, .slow_i(slow), .req_i(req),
      .pin_b_o({receiver_ready_in_b_i, rate_indication_in_b_i,
      standby_indicator_in_b_i, signal_quality_in_b_i, test_mode_in_b_i,
      incoming_call_in_b_i}));
   msc_modem_ext uut (.ref_clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i,
      .hwrite_i, .hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i,
      .hrdata_o, .hreadyout_o, .hresp_o, .irq_o, .incoming_call_in_b_i,
      .test_mode_in_b_i, .signal_quality_in_b_i, .standby_indicator_in_b_i,
      .rate_indication_in_b_i, .receiver_ready_in_b_i, .tx_empty_i,
      .terminal_in_service_out_b_o, .frequency_select_out_b_o,
      .select_standby_out_b_o, .remote_loopback_out_b_o,
      .local_loopback_out_b_o, .new_signal_out_b_o,
      .change_or_tx_empty_pin_b_o);
   initial forever #4 ref_clk_i = ~ref_clk_i;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : wt
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : check
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
      hsel_i <= 1'b1;
      htrans_i <= MSC_HTRANS_NONSEQ;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= {24'h0, d};
      do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back({24'h0, e});
      xfer(a, 1'b0, 8'h00);
   endtask : rd
   task automatic conclude();
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // Read data is taken where the wait state ends
   always @(posedge ref_clk_i) begin
      if (dph_rd && hreadyout_o === 1'b1)
         check(hrdata_o, expq.pop_front());
      if (hreadyout_o === 1'b1)
         dph_rd <= hsel_i && htrans_i == MSC_HTRANS_NONSEQ && !hwrite_i;
   end
   initial begin
      wt(4000);
      n_errors++;
      $display("Error %0t: timeout", $time);
      conclude();
   end
   initial begin
      logic [31:0] r;
      wt(16);
      rst_b_i <= 1'b1;
      wt(1);
      rd(MSC_OFF_OUTPUT, 8'h00);
      check(new_signal_out_b_o, 1'b1);
      $display("Test reset done");
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         slow <= r[8];
         req <= {1'b0, r[4:0]};
         wr(MSC_OFF_STATUS_TWO, ~r[7:0]);
         wt(10);
         rd(MSC_OFF_STATUS_TWO, {~r[7:5], r[4:0]});
      end
      rd(MSC_OFF_STATUS_ONE, 8'h00);
      $display("Test mirror done");
      slow <= 1'b0;
      req <= '0;
      wt(10);
      wr(MSC_OFF_IRQ_MSK, 8'h01);
      for (int i = 0; i < 5; i++) begin
         r = 32'h20 << ((i < 2) ? i : 2);
         wr(MSC_OFF_CONTROL, i[0] ? 8'h04 : 8'h01);
         wr(MSC_OFF_STATUS_TWO, 8'hE0 ^ r[7:0]);
         req[i] <= ~req[i];
         wt(8);
         rd(MSC_OFF_STATUS_ONE, 8'h00);
         wr(MSC_OFF_STATUS_TWO, r[7:0]);
         req[i] <= ~req[i];
         wt(8);
         check(change_or_tx_empty_pin_b_o, 1'b0);
         check(irq_o, 1'b1);
         rd(MSC_OFF_STATUS_ONE, 8'h04);
         rd(MSC_OFF_STATUS_ONE, 8'h00);
         wr(MSC_OFF_IRQ_STS, 8'h01);
         wt(1);
         check(irq_o, 1'b0);
      end
      wr(MSC_OFF_IRQ_MSK, 8'h00);
      wr(MSC_OFF_STATUS_TWO, 8'h20);
      req[0] <= 1'b1;
      wt(8);
      check(irq_o, 1'b0);
      wr(MSC_OFF_IRQ_MSK, 8'h01);
      wt(1);
      check(irq_o, 1'b1);
      wr(MSC_OFF_IRQ_STS, 8'h01);
      rd(MSC_OFF_STATUS_ONE, 8'h04);
      $display("Test change done");
      req[5] <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         wr(MSC_OFF_OUTPUT, {r[7:1], 1'b1});
         wt(1);
         check(opins, {27'h000_0000, ~r[5:1]});
         check(new_signal_out_b_o, 1'b0);
         rd(MSC_OFF_OUTPUT, {2'h0, r[5:1], 1'b1});
      end
      wr(MSC_OFF_OUTPUT, 8'h00);
      wt(8);
      check(new_signal_out_b_o, 1'b0);
      req[5] <= 1'b0;
      wt(8);
      check(new_signal_out_b_o, 1'b1);
      tx_empty_i <= 1'b1;
      wt(2);
      check(change_or_tx_empty_pin_b_o, 1'b0);
      tx_empty_i <= 1'b0;
      rd(MSC_OFF_IRQ_STS, 8'h02);
      rd(MSC_OFF_IRQ_MSK, 8'h01);
      rd(MSC_OFF_CONTROL, 8'h01);
      check(irq_o, 1'b0);
      check(hresp_o, 1'b0);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      $display("Test output done");
      conclude();
   end
endmodule : msc_modem_ext_tb

// file: msc_modem_monitor.sv
module msc_modem_monitor
   import msc_pkg::*;
#(
   parameter int ADDR_W = MSC_ADDR_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [ADDR_W-1:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [MSC_DATA_W-1:0] hwdata_i,
   input wire logic [MSC_DATA_W-1:0] hrdata_o,
   input wire logic incoming_call_in_b_i,
   input wire logic test_mode_in_b_i,
   input wire logic signal_quality_in_b_i,
   input wire logic standby_indicator_in_b_i,
   input wire logic rate_indication_in_b_i,
   input wire logic receiver_ready_in_b_i,
   input wire logic tx_empty_i,
   input wire logic terminal_in_service_out_b_o,
   input wire logic frequency_select_out_b_o,
   input wire logic select_standby_out_b_o,
   input wire logic remote_loopback_out_b_o,
   input wire logic local_loopback_out_b_o,
   input wire logic new_signal_out_b_o,
   input wire logic change_or_tx_empty_pin_b_o
);
   logic [4:0] ins, opins;
   logic wo, rdx;
   assign ins = {rate_indication_in_b_i, standby_indicator_in_b_i,
      signal_quality_in_b_i, test_mode_in_b_i, incoming_call_in_b_i};
   assign opins = {terminal_in_service_out_b_o, frequency_select_out_b_o,
      select_standby_out_b_o, remote_loopback_out_b_o,
      local_loopback_out_b_o};
   assign rdx = hsel_i && hready_i && htrans_i == MSC_HTRANS_NONSEQ;
   assign wo = rdx && hwrite_i && haddr_i[7:2] == MSC_OFF_OUTPUT[7:2];
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_newsig_set: assert property (wo ##1 hwdata_i[MSC_OUT_NEWSIG]
      |=> !new_signal_out_b_o) else $error("new signal not low");
   a_out_pins: assert property (wo ##1 1'b1
      |=> opins == ~$past(hwdata_i[5:1])) else $error("output pins wrong");
   a_out_hold: assert property ($changed(opins) |-> $past(wo, 2))
      else $error("output pins moved without write");
   a_newsig_release: assert property ($rose(new_signal_out_b_o)
      |-> $past(receiver_ready_in_b_i, 2) || $past(receiver_ready_in_b_i, 3)
      || $past(receiver_ready_in_b_i, 4)) else $error("early release");
   a_newsig_hold: assert property (
      (!new_signal_out_b_o && !receiver_ready_in_b_i) [*4]
      |=> !new_signal_out_b_o) else $error("new signal not held");
   a_tx_pin: assert property (tx_empty_i
      |=> !change_or_tx_empty_pin_b_o) else $error("shared pin high");
   a_mirror_rd: assert property ($stable(ins) [*4] ##0 (rdx &&
      !hwrite_i && haddr_i[7:2] == MSC_OFF_STATUS_TWO[7:2])
      |-> ##2 hrdata_o[4:0] == ~$past(ins, 2)) else $error("mirror wrong");
   a_out_top: assert property (rdx && !hwrite_i &&
      haddr_i[7:2] == MSC_OFF_OUTPUT[7:2] |-> ##2 hrdata_o[31:6] == '0)
      else $error("output top bits set");
   c_wr_newsig: cover property (wo ##1 hwdata_i[MSC_OUT_NEWSIG]);
   c_change: cover property ($fell(change_or_tx_empty_pin_b_o));
   c_release: cover property ($rose(new_signal_out_b_o));
endmodule : msc_modem_monitor

bind msc_modem_ext msc_modem_monitor #(.ADDR_W(ADDR_W)) mon (.ref_clk_i,
   .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hwdata_i,
   .hrdata_o, .incoming_call_in_b_i, .test_mode_in_b_i,
   .signal_quality_in_b_i, .standby_indicator_in_b_i,
   .rate_indication_in_b_i, .receiver_ready_in_b_i, .tx_empty_i,
   .terminal_in_service_out_b_o, .frequency_select_out_b_o,
   .select_standby_out_b_o, .remote_loopback_out_b_o,
   .local_loopback_out_b_o, .new_signal_out_b_o,
   .change_or_tx_empty_pin_b_o);

// file: msc_pkg.sv
// How it works
// - Status-two bits 0 to 4 mirror incoming call, test mode, signal quality, standby and rate indication in that order.
// - A mirrored status bit reads 1 while its modem input is low and 0 while it is high.
// - The five mirrored bits are read-only, ignore writes and always follow the inputs.
// - With status-two bit 5 set, any change on the incoming-call input raises the change event.
// - With status-two bit 6 set, any change on the test-mode input raises the change event.
// - With status-two bit 7 set, a change on signal quality, rate indication or standby raises the change event.
// - Each enabled change event sets the change flag, bit 2 of status one, and pulls the shared pin low.
// - Status-two bits 5 to 7 are writable and read back the last value written.
// - Output register bits 5 to 1 drive in-service, frequency select, standby select, remote and local loopback, 1 driving low.
// - Writing 1 to output bit 0 drives the new-signal output low at once.
// - With output bit 0 cleared, new-signal holds its level until receiver ready goes high, then returns high.
// - Reading status one clears the change flag.
// - While the change flag is set the shared change/transmit-empty pin is low.
// - Change detection feeds the flag only while transmit enable or receive enable is 1.
package msc_pkg;
   localparam int MSC_ADDR_W = 8;
   localparam int MSC_DATA_W = 32;
   localparam int MSC_NUM_STS = 5;
   localparam int MSC_NUM_OUT = 6;
   localparam int MSC_NUM_IEN = 3;
   localparam int MSC_NUM_SYNC = MSC_NUM_STS + 1;

   // Byte offsets
   localparam logic [7:0] MSC_OFF_STATUS_TWO = 8'h00;
   localparam logic [7:0] MSC_OFF_OUTPUT = 8'h04;
   localparam logic [7:0] MSC_OFF_STATUS_ONE = 8'h08;
   localparam logic [7:0] MSC_OFF_CONTROL = 8'h0C;
   localparam logic [7:0] MSC_OFF_IRQ_STS = 8'h10;
   localparam logic [7:0] MSC_OFF_IRQ_MSK = 8'h14;

   // Status-two fields
   localparam int MSC_S2_CALL = 0;
   localparam int MSC_S2_TEST = 1;
   localparam int MSC_S2_QUAL = 2;
   localparam int MSC_S2_STBY = 3;
   localparam int MSC_S2_RATE = 4;
   localparam int MSC_S2_IEN = 5;
   localparam int MSC_IEN_CALL = 0;
   localparam int MSC_IEN_TEST = 1;
   localparam int MSC_IEN_GRP = 2;

   // Output register fields
   localparam int MSC_OUT_NEWSIG = 0;
   localparam int MSC_OUT_LOCAL = 1;
   localparam int MSC_OUT_REMOTE = 2;
   localparam int MSC_OUT_STBY = 3;
   localparam int MSC_OUT_FREQ = 4;
   localparam int MSC_OUT_INSVC = 5;

   // Status-one, control and interrupt fields
   localparam int MSC_S1_CHG = 2;
   localparam int MSC_CTL_TX_ON = 0;
   localparam int MSC_CTL_RX_ON = 2;
   localparam int MSC_IRQ_CHG = 0;
   localparam int MSC_IRQ_NSREL = 1;
   localparam int MSC_NUM_IRQ = 2;

   // Sync index of receiver ready
   localparam int MSC_SYNC_RDY = 5;

   // Reset values
   localparam logic [MSC_NUM_IEN-1:0] MSC_RST_IEN = 3'h0;
   localparam logic [MSC_NUM_OUT-1:0] MSC_RST_OUT = 6'h00;
   localparam logic [1:0] MSC_RST_CTL = 2'h0;
   localparam logic [MSC_NUM_IRQ-1:0] MSC_RST_IRQ = 2'h0;
   localparam logic [MSC_DATA_W-1:0] MSC_RST_RDATA = 32'h0000_0000;
   localparam logic MSC_RST_PIN = 1'h1;

   localparam logic [1:0] MSC_HTRANS_NONSEQ = 2'h2;
endpackage : msc_pkg

// file: msc_sync.sv
module msc_sync
   import msc_pkg::*;
#(
   parameter int W = MSC_NUM_SYNC
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } msc_sync_state_t;

   msc_sync_state_t s_q;
   msc_sync_state_t s_d;

   if (W < 1) begin : g_chk
      $error("msc_sync needs W of at least 1");
   end

   // Idle modem lines sit high
   always_comb begin
      s_d = s_q;
      s_d.s1 = async_i;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.s2;
endmodule : msc_sync
